// *** include/pll_ctl_consts.vh ***
// constants for the divider and lock control block
`ifndef PLL_CTL_CONSTS_VH
`define PLL_CTL_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_DIV_CFG 8'h04
`define OFS_LOCK_CFG 8'h08
`define OFS_SKEW_CFG 8'h0C
`define OFS_STATUS 8'h10
`define OFS_INT_STATUS 8'h14
`define OFS_INT_EN 8'h18
`define OFS_INT_CLR 8'h1C

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_BYPASS_BIT 0
`define CTRL_FBSEL_LSB 1
`define DIV_FIELD_W 5
`define DIV0_LSB 0
`define DIV1_LSB 8
`define DIV2_LSB 16
`define SKEW_FIELD_W 4
`define SKEW0_LSB 0
`define SKEW1_LSB 4
`define SKEW2_LSB 8
`define INT_LOCK_GAIN_BIT 0
`define INT_LOCK_LOSS_BIT 1
`define INT_BAD_RATIO_BIT 2

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define CTRL_RESET 3'h0
`define DIV_RESET 5'h00
`define LOCK_CFG_RESET 9'h010
`define LOCK_COUNT_MIN 9'h010
`define LOCK_COUNT_MAX 9'h100
`define SKEW_RESET 4'h0
`define INT_RESET 3'h0

`endif

// *** rtl/pow2_divider.v ***
// static power-of-two clock divider fed by a sampled source clock
`timescale 1ns/10ps
module pow2_divider #(
	parameter W = 5
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// source and setting
	input wire src_level,
	input wire src_rise,
	input wire [W-1:0] ratio_m1,
	input wire invert_unity,
	// divided clock
	output wire div_out,
	output wire div_rise
);

reg [W-1:0] cnt_reg;
reg [W-1:0] cnt_next;
reg out_reg;
reg out_next;
reg rise_reg;
reg rise_next;
wire [W-1:0] half_m1 = ratio_m1 >> 1;

// ----------------------------------------
// counting only on source edges keeps it static
// ----------------------------------------
always @* begin
	cnt_next = cnt_reg;
	out_next = out_reg;
	rise_next = 1'b0;
	if (ratio_m1 == {W{1'b0}}) begin
		cnt_next = {W{1'b0}};
		out_next = invert_unity ? ~src_level : src_level;
		rise_next = out_next & ~out_reg;
	end else if (src_rise) begin
		if (cnt_reg >= half_m1) begin
			cnt_next = {W{1'b0}};
			out_next = ~out_reg;
			rise_next = ~out_reg;
		end else begin
			cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
		end
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt_reg <= {W{1'b0}};
		out_reg <= 1'b0;
		rise_reg <= 1'b0;
	end else begin
		cnt_reg <= cnt_next;
		out_reg <= out_next;
		rise_reg <= rise_next;
	end
end

assign div_out = out_reg;
assign div_rise = rise_reg;

endmodule

// *** rtl/lock_detector.v ***
// edge-based phase comparison and lock qualification counter
`timescale 1ns/10ps
module lock_detector #(
	parameter CW = 9
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// comparison inputs
	input wire enable,
	input wire ref_rise,
	input wire fb_rise,
	input wire [CW-1:0] threshold,
	// lock flag
	output wire lock
);

reg [1:0] fb_seen_reg;
reg [1:0] fb_seen_next;
reg [CW-1:0] cnt_reg;
reg [CW-1:0] cnt_next;
reg lock_reg;
reg lock_next;
reg good;

// ----------------------------------------
// one feedback edge per reference period is in window
// ----------------------------------------
always @* begin
	fb_seen_next = fb_seen_reg;
	cnt_next = cnt_reg;
	lock_next = lock_reg;
	good = (fb_seen_reg == 2'h1);
	if (!enable) begin
		fb_seen_next = 2'h0;
		cnt_next = {CW{1'b0}};
		lock_next = 1'b0;
	end else if (ref_rise) begin
		fb_seen_next = fb_rise ? 2'h1 : 2'h0;
		if (good) begin
			if (cnt_reg < threshold)
				cnt_next = cnt_reg + {{(CW-1){1'b0}}, 1'b1};
			lock_next = lock_reg | (cnt_next >= threshold);
		end else begin
			cnt_next = {CW{1'b0}};
			lock_next = 1'b0;
		end
	end else if (fb_rise && fb_seen_reg != 2'h3) begin
		fb_seen_next = fb_seen_reg + 2'h1;
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		fb_seen_reg <= 2'h0;
		cnt_reg <= {CW{1'b0}};
		lock_reg <= 1'b0;
	end else begin
		fb_seen_reg <= fb_seen_next;
		cnt_reg <= cnt_next;
		lock_reg <= lock_next;
	end
end

assign lock = lock_reg;

endmodule

// *** rtl/pll_divider_lock_control.v ***
// top of the divider, lock detect and skew control block with its APB registers
// What this block does
// - the lock output is high while the loop is locked.
// - lock is raised only after a programmed run of 16 to 256 good comparisons.
// - lock falls at once when a comparison fails, with no count.
// - three dividers, each with its own 5-bit setting, divide the oscillator clock.
// - each divider takes a ratio of 1, 2, 4, 8, 16 or 32 and no other.
// - any divider may be chosen as the feedback that closes the loop.
// - with bypass high the reference clock feeds all three dividers.
// - bypass disables lock detection and skew generation.
// - in bypass a divider at ratio 1 gives the inverted reference clock.
// - the phase comparator acts on rising edges only.
// - skew delay is counted in fixed fractions of the oscillator period.
// - eight skew steps, a fine step one sixteenth and a coarse one an eighth of a period.
// - skew applies only to divider outputs and only while the loop is active.
// - the divider chain is static, following references down to zero frequency.
`timescale 1ns/10ps
`include "pll_ctl_consts.vh"
module pll_divider_lock_control (
	// clock and reset
	input wire I_CORE_CLK,
	input wire I_RSTN,
	// sampled clocks
	input wire I_REF_CLK,
	input wire I_OSC_CLK,
	// apb slave
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output wire [31:0] O_PRDATA,
	output wire O_PREADY,
	output wire O_PSLVERR,
	// clock, lock and interrupt outputs
	output wire [2:0] O_DIV_CLK,
	output wire O_LOCK,
	output wire O_IRQ,
	// skew delays in sixteenths of an oscillator period
	output wire [4:0] O_SKEW0,
	output wire [4:0] O_SKEW1,
	output wire [4:0] O_SKEW2
);

// ----------------------------------------
// helpers
// ----------------------------------------
function legal_ratio;
	input [4:0] v;
	begin
		legal_ratio = (v == 5'h00) | (v == 5'h01) | (v == 5'h03) | (v == 5'h07) |
			(v == 5'h0F) | (v == 5'h1F);
	end
endfunction

function [8:0] clamp_lock;
	input [8:0] v;
	begin
		if (v < `LOCK_COUNT_MIN)
			clamp_lock = `LOCK_COUNT_MIN;
		else if (v > `LOCK_COUNT_MAX)
			clamp_lock = `LOCK_COUNT_MAX;
		else
			clamp_lock = v;
	end
endfunction

function [4:0] skew_units;
	input [3:0] cfg;
	input active;
	begin
		if (!active)
			skew_units = 5'h00;
		else if (cfg[3])
			skew_units = {1'b0, cfg[2:0], 1'b0};
		else
			skew_units = {2'b00, cfg[2:0]};
	end
endfunction

// ----------------------------------------
// reset release
// ----------------------------------------
reg rst_meta_reg;
reg rst_sync_reg;
wire rst_n = rst_sync_reg;

always @(posedge I_CORE_CLK or negedge I_RSTN) begin
	if (!I_RSTN) begin
		rst_meta_reg <= 1'b0;
		rst_sync_reg <= 1'b0;
	end else begin
		rst_meta_reg <= 1'b1;
		rst_sync_reg <= rst_meta_reg;
	end
end

// ----------------------------------------
// registers
// ----------------------------------------
reg bypass_reg;
reg [1:0] fbsel_reg;
reg [4:0] div0_reg;
reg [4:0] div1_reg;
reg [4:0] div2_reg;
reg [8:0] lock_cfg_reg;
reg [3:0] skew0_reg;
reg [3:0] skew1_reg;
reg [3:0] skew2_reg;
reg [2:0] int_st_reg;
reg [2:0] int_en_reg;
reg pready_reg;
reg pslverr_reg;
reg [31:0] prdata_reg;
reg irq_reg;
reg lock_prev_reg;
reg [4:0] sk0_reg;
reg [4:0] sk1_reg;
reg [4:0] sk2_reg;

reg [2:0] int_st_next;
reg [2:0] int_set;
reg [2:0] int_clr;
reg bad_ratio;
reg [31:0] rdata;
reg err;

wire lock_flag;
wire [2:0] div_out;
wire [2:0] div_rise;
wire access = I_PSEL & I_PENABLE & ~pready_reg;
wire wr = access & I_PWRITE;

// ----------------------------------------
// clock sampling and source steering
// ----------------------------------------
reg ref_d_reg;
reg osc_d_reg;
wire ref_rise = I_REF_CLK & ~ref_d_reg;
wire osc_rise = I_OSC_CLK & ~osc_d_reg;
wire src_level = bypass_reg ? I_REF_CLK : I_OSC_CLK;
wire src_rise = bypass_reg ? ref_rise : osc_rise;
wire fb_rise = (fbsel_reg == 2'h1) ? div_rise[1] :
	(fbsel_reg == 2'h2) ? div_rise[2] : div_rise[0];

always @(posedge I_CORE_CLK or negedge rst_n) begin
	if (!rst_n) begin
		ref_d_reg <= 1'b0;
		osc_d_reg <= 1'b0;
	end else begin
		ref_d_reg <= I_REF_CLK;
		osc_d_reg <= I_OSC_CLK;
	end
end

// ----------------------------------------
// dividers and lock detector
// ----------------------------------------
pow2_divider #(.W(`DIV_FIELD_W)) u_div0 (
	.clk(I_CORE_CLK),
	.rst_n(rst_n),
	.src_level(src_level),
	.src_rise(src_rise),
	.ratio_m1(div0_reg),
	.invert_unity(bypass_reg),
	.div_out(div_out[0]),
	.div_rise(div_rise[0])
);

pow2_divider #(.W(`DIV_FIELD_W)) u_div1 (
	.clk(I_CORE_CLK),
	.rst_n(rst_n),
	.src_level(src_level),
	.src_rise(src_rise),
	.ratio_m1(div1_reg),
	.invert_unity(bypass_reg),
	.div_out(div_out[1]),
	.div_rise(div_rise[1])
);

pow2_divider #(.W(`DIV_FIELD_W)) u_div2 (
	.clk(I_CORE_CLK),
	.rst_n(rst_n),
	.src_level(src_level),
	.src_rise(src_rise),
	.ratio_m1(div2_reg),
	.invert_unity(bypass_reg),
	.div_out(div_out[2]),
	.div_rise(div_rise[2])
);

lock_detector #(.CW(9)) u_lock (
	.clk(I_CORE_CLK),
	.rst_n(rst_n),
	.enable(~bypass_reg),
	.ref_rise(ref_rise),
	.fb_rise(fb_rise),
	.threshold(lock_cfg_reg),
	.lock(lock_flag)
);

// ----------------------------------------
// read mux and event collection
// ----------------------------------------
always @* begin
	rdata = 32'h00000000;
	err = 1'b0;
	case (I_PADDR)
	`OFS_CTRL: rdata = {29'h0, fbsel_reg, bypass_reg};
	`OFS_DIV_CFG: rdata = {11'h0, div2_reg, 3'h0, div1_reg, 3'h0, div0_reg};
	`OFS_LOCK_CFG: rdata = {23'h0, lock_cfg_reg};
	`OFS_SKEW_CFG: rdata = {20'h0, skew2_reg, skew1_reg, skew0_reg};
	`OFS_STATUS: rdata = {28'h0, div_out, lock_flag};
	`OFS_INT_STATUS: rdata = {29'h0, int_st_reg};
	`OFS_INT_EN: rdata = {29'h0, int_en_reg};
	`OFS_INT_CLR: rdata = 32'h00000000;
	default: err = 1'b1;
	endcase
	bad_ratio = wr & (I_PADDR == `OFS_DIV_CFG) &
		~(legal_ratio(I_PWDATA[4:0]) & legal_ratio(I_PWDATA[12:8]) &
		legal_ratio(I_PWDATA[20:16]));
	int_set = 3'h0;
	int_set[`INT_LOCK_GAIN_BIT] = lock_flag & ~lock_prev_reg;
	int_set[`INT_LOCK_LOSS_BIT] = ~lock_flag & lock_prev_reg;
	int_set[`INT_BAD_RATIO_BIT] = bad_ratio;
	int_clr = (wr && I_PADDR == `OFS_INT_CLR) ? I_PWDATA[2:0] : 3'h0;
	// a new event outlasts a clear in the same cycle
	int_st_next = (int_st_reg & ~int_clr) | int_set;
end

// ----------------------------------------
// register writes and apb answer
// ----------------------------------------
always @(posedge I_CORE_CLK or negedge rst_n) begin
	if (!rst_n) begin
		bypass_reg <= 1'b0;
		fbsel_reg <= 2'h0;
		div0_reg <= `DIV_RESET;
		div1_reg <= `DIV_RESET;
		div2_reg <= `DIV_RESET;
		lock_cfg_reg <= `LOCK_CFG_RESET;
		skew0_reg <= `SKEW_RESET;
		skew1_reg <= `SKEW_RESET;
		skew2_reg <= `SKEW_RESET;
		int_st_reg <= `INT_RESET;
		int_en_reg <= `INT_RESET;
		pready_reg <= 1'b0;
		pslverr_reg <= 1'b0;
		prdata_reg <= 32'h00000000;
		irq_reg <= 1'b0;
		lock_prev_reg <= 1'b0;
		sk0_reg <= 5'h00;
		sk1_reg <= 5'h00;
		sk2_reg <= 5'h00;
	end else begin
		pready_reg <= access;
		pslverr_reg <= access & err;
		prdata_reg <= (access & ~I_PWRITE & ~err) ? rdata : 32'h00000000;
		int_st_reg <= int_st_next;
		irq_reg <= |(int_st_next & int_en_reg);
		lock_prev_reg <= lock_flag;
		sk0_reg <= skew_units(skew0_reg, ~bypass_reg);
		sk1_reg <= skew_units(skew1_reg, ~bypass_reg);
		sk2_reg <= skew_units(skew2_reg, ~bypass_reg);
		if (wr) begin
			case (I_PADDR)
			`OFS_CTRL: begin
				bypass_reg <= I_PWDATA[`CTRL_BYPASS_BIT];
				// only three dividers exist, a fourth code is refused
				if (I_PWDATA[`CTRL_FBSEL_LSB+1:`CTRL_FBSEL_LSB] != 2'h3)
					fbsel_reg <= I_PWDATA[`CTRL_FBSEL_LSB+1:`CTRL_FBSEL_LSB];
			end
			`OFS_DIV_CFG: begin
				// illegal fields keep their old ratio
				if (legal_ratio(I_PWDATA[4:0]))
					div0_reg <= I_PWDATA[4:0];
				if (legal_ratio(I_PWDATA[12:8]))
					div1_reg <= I_PWDATA[12:8];
				if (legal_ratio(I_PWDATA[20:16]))
					div2_reg <= I_PWDATA[20:16];
			end
			`OFS_LOCK_CFG: lock_cfg_reg <= clamp_lock(I_PWDATA[8:0]);
			`OFS_SKEW_CFG: begin
				skew0_reg <= I_PWDATA[3:0];
				skew1_reg <= I_PWDATA[7:4];
				skew2_reg <= I_PWDATA[11:8];
			end
			`OFS_INT_EN: int_en_reg <= I_PWDATA[2:0];
			default: begin
			end
			endcase
		end
	end
end

assign O_PRDATA = prdata_reg;
assign O_PREADY = pready_reg;
assign O_PSLVERR = pslverr_reg;
assign O_DIV_CLK = div_out;
assign O_LOCK = lock_flag;
assign O_IRQ = irq_reg;
assign O_SKEW0 = sk0_reg;
assign O_SKEW1 = sk1_reg;
assign O_SKEW2 = sk2_reg;

endmodule

// *** testbench/ref_osc_source.sv ***
// reference and oscillator clock source model
`timescale 1ns/10ps
module ref_osc_source (
	input wire clk,
	input wire [7:0] ref_half,
	output reg ref_clk = 1'b0,
	output reg osc_clk = 1'b0
);
	reg [7:0] cnt = 8'h00;
	// whole core cycles per level so no level is missed; zero half period parks it
	always @(posedge clk) begin
		osc_clk <= ~osc_clk;
		cnt <= cnt + 8'h01;
		if (ref_half != 8'h00 && cnt + 8'h01 >= ref_half) begin
			cnt <= 8'h00;
			ref_clk <= ~ref_clk;
		end
	end
endmodule

// *** testbench/pll_ctl_properties.sv ***
// port assertions for the divider and lock control block
`timescale 1ns/10ps
`include "pll_ctl_consts.vh"
module pll_ctl_checker (
	input wire I_CORE_CLK,
	input wire I_RSTN,
	input wire I_REF_CLK,
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	input wire [2:0] O_DIV_CLK,
	input wire O_LOCK,
	input wire O_IRQ,
	input wire [4:0] O_SKEW0,
	input wire [4:0] O_SKEW1,
	input wire [4:0] O_SKEW2
);
	wire wr = I_PSEL && I_PENABLE && I_PWRITE && !O_PREADY;
	wire bad = (I_PADDR > `OFS_INT_CLR) || (I_PADDR[1:0] != 2'h0);
	wire legal0 = (I_PWDATA[4:0] & (I_PWDATA[4:0] + 5'h01)) == 5'h00;
	reg byp_reg, one_reg, ref_reg, lock_reg;
	reg [2:0] en_reg;
	reg [8:0] refs_reg;
	always @(posedge I_CORE_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			byp_reg <= 1'b0;
			one_reg <= 1'b1;
			ref_reg <= 1'b0;
			lock_reg <= 1'b0;
			en_reg <= 3'h0;
			refs_reg <= 9'h000;
		end else begin
			ref_reg <= I_REF_CLK;
			lock_reg <= O_LOCK;
			if (wr && I_PADDR == `OFS_CTRL)
				byp_reg <= I_PWDATA[0];
			if (wr && I_PADDR == `OFS_DIV_CFG && legal0)
				one_reg <= I_PWDATA[4:0] == 5'h00;
			if (wr && I_PADDR == `OFS_INT_EN)
				en_reg <= I_PWDATA[2:0];
			// counts every rising reference edge, so it bounds the good run from above
			if (byp_reg || (lock_reg && !O_LOCK))
				refs_reg <= 9'h000;
			else if (I_REF_CLK && !ref_reg && refs_reg != 9'h1FF)
				refs_reg <= refs_reg + 9'h001;
		end
	end
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RSTN);
	sequence s_taken;
		I_PSEL && I_PENABLE && !O_PREADY;
	endsequence
	sequence s_ref_steady;
		$stable(I_REF_CLK) [*3];
	endsequence
	property p_answer;
		s_taken |=> O_PREADY ##1 !O_PREADY;
	endproperty
	property p_slverr;
		(O_PREADY || O_PSLVERR) |-> O_PREADY && O_PSLVERR == bad;
	endproperty
	property p_rdata_idle;
		!O_PREADY |-> O_PRDATA == 32'h0;
	endproperty
	property p_lock_min;
		$rose(O_LOCK) |-> refs_reg >= 9'h010;
	endproperty
	property p_byp_quiet;
		byp_reg && $past(byp_reg) |-> !O_LOCK && {O_SKEW0, O_SKEW1, O_SKEW2} == 15'h0;
	endproperty
	property p_byp_invert;
		(s_ref_steady ##0 (byp_reg && one_reg && $past(byp_reg, 3) && $past(one_reg, 3)))
			|-> O_DIV_CLK[0] == !I_REF_CLK;
	endproperty
	property p_reset_low;
		$rose(I_RSTN) |-> (O_DIV_CLK == 3'h0 && !O_LOCK) [*2];
	endproperty
	property p_irq_mask;
		en_reg == 3'h0 && $past(en_reg) == 3'h0 |-> !O_IRQ;
	endproperty
	a_answer: assert property (p_answer) else $error("ready pulse wrong");
	a_slverr: assert property (p_slverr) else $error("error flag wrong");
	a_rdata_idle: assert property (p_rdata_idle) else $error("idle read data not zero");
	a_lock_min: assert property (p_lock_min) else $error("lock too early");
	a_byp_quiet: assert property (p_byp_quiet) else $error("bypass not quiet");
	a_byp_invert: assert property (p_byp_invert) else $error("unity not inverted");
	a_reset_low: assert property (p_reset_low) else $error("outputs high in reset");
	a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
endmodule
bind pll_divider_lock_control pll_ctl_checker i_chk (.I_CORE_CLK(I_CORE_CLK),
	.I_RSTN(I_RSTN), .I_REF_CLK(I_REF_CLK), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_DIV_CLK(O_DIV_CLK), .O_LOCK(O_LOCK),
	.O_IRQ(O_IRQ), .O_SKEW0(O_SKEW0), .O_SKEW1(O_SKEW1), .O_SKEW2(O_SKEW2));

// *** testbench/testbench.sv ***
// self-checking bench for the divider and lock control block
`timescale 1ns/10ps
`include "pll_ctl_consts.vh"
module testbench;
	reg core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	reg [7:0] paddr = 8'h00, ref_half = 8'h02;
	reg [31:0] pwdata = 32'h0, rd, d, seed;
	wire [31:0] prdata;
	wire pready, pslverr, lock, irq, ref_clk, osc_clk;
	wire [2:0] div_clk;
	wire [4:0] sk0, sk1, sk2;
	wire [3:0] mon = {ref_clk, div_clk};
	integer n_errors = 0, compares = 0, i, j, k, fb, e[0:2], rises[0:3];
	always #2 core_clk = ~core_clk;
	ref_osc_source i_src (.clk(core_clk), .ref_half(ref_half), .ref_clk(ref_clk),
		.osc_clk(osc_clk));
	pll_divider_lock_control i_dut (.I_CORE_CLK(core_clk), .I_RSTN(rstn), .I_REF_CLK(ref_clk),
		.I_OSC_CLK(osc_clk), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_DIV_CLK(div_clk), .O_LOCK(lock), .O_IRQ(irq),
		.O_SKEW0(sk0), .O_SKEW1(sk1), .O_SKEW2(sk2));
	task check(input [31:0] seen, input [31:0] exp);
		begin
			compares = compares + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task results;
		begin
			$display("compares %0d n_errors %0d", compares, n_errors);
			if (n_errors == 0 && compares > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// ready is read at the rising edge before that edge's updates, i.e. as sampled there
	task apb(input w, input [7:0] a, input [31:0] wd);
		begin
			@(posedge core_clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= wd;
			@(posedge core_clk);
			penable <= 1'b1;
			k = 0;
			@(posedge core_clk);
			while (pready !== 1'b1 && k < 20) begin
				@(posedge core_clk);
				k = k + 1;
			end
			check(k < 20, 32'h1);
			rd = prdata;
			err = pslverr;
			// released at the ready edge so no second access is taken
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task measure(input integer n);
		reg [3:0] p;
		begin
			for (i = 0; i < 4; i = i + 1) rises[i] = 0;
			@(negedge core_clk);
			p = mon;
			repeat (n) begin
				@(negedge core_clk);
				for (i = 0; i < 4; i = i + 1) if (mon[i] && !p[i]) rises[i] = rises[i] + 1;
				p = mon;
			end
		end
	endtask
	function near(input integer a, input integer b);
		near = a >= b - 1 && a <= b + 1;
	endfunction
	function [14:0] skew_of(input [11:0] c);
		integer n;
		for (n = 0; n < 3; n = n + 1) skew_of[n * 5 +: 5] = c[n * 4 +: 3] << c[n * 4 + 3];
	endfunction
	initial begin
		seed = $urandom(32'hDF9B);
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (i = 0; i < 8; i = i + 1) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			check(i == 4 ? rd & 32'h1 : rd, i == 2 ? 32'h10 : 32'h0);
		end
		apb(1'b0, 8'h20, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
		for (j = 0; j < 3; j = j + 1) begin
			d = j == 0 ? 32'd300 : j == 1 ? 32'd5 : 32'd16 + $urandom % 241;
			apb(1'b1, `OFS_LOCK_CFG, d);
			apb(1'b0, `OFS_LOCK_CFG, 32'h0);
			check(rd, d > 256 ? 32'h100 : d < 16 ? 32'h10 : d);
		end
		$display("test registers done");
		for (j = 0; j < 3; j = j + 1) begin
			fb = $urandom % 3;
			for (i = 0; i < 3; i = i + 1) e[i] = $urandom % 6;
			if (j == 0) e[fb] = 5;
			apb(1'b1, `OFS_CTRL, 32'h1);
			ref_half <= 8'(1 << e[fb]);
			d = {11'h0, 5'((1 << e[2]) - 1), 3'h0, 5'((1 << e[1]) - 1), 3'h0, 5'((1 << e[0]) - 1)};
			apb(1'b1, `OFS_DIV_CFG, d);
			apb(1'b1, `OFS_CTRL, 32'(fb << 1));
			apb(1'b1, `OFS_LOCK_CFG, j == 0 ? 32'h100 : 32'h10);
			for (k = 0; lock !== 1'b1 && k < 20000; k = k + 1) @(posedge core_clk);
			check(lock, 1'b1);
			apb(1'b0, `OFS_STATUS, 32'h0);
			check(rd & 32'h1, 32'h1);
			measure(2048);
			for (i = 0; i < 3; i = i + 1) check(near(rises[i], rises[3] * (1 << e[fb]) / (1 << e[i])), 1'b1);
			d = $urandom & 32'hFFF;
			apb(1'b1, `OFS_SKEW_CFG, d);
			repeat (2) @(posedge core_clk);
			check({sk2, sk1, sk0}, skew_of(d[11:0]));
		end
		$display("test lock done");
		apb(1'b1, `OFS_INT_EN, 32'h7);
		apb(1'b1, `OFS_INT_CLR, 32'h7);
		ref_half <= ref_half << 1;
		for (k = 0; lock !== 1'b0 && k < 300; k = k + 1) @(posedge core_clk);
		check(k < 300, 32'h1);
		repeat (2) @(posedge core_clk);
		check(irq, 1'b1);
		apb(1'b1, `OFS_DIV_CFG, 32'h001F0302);
		apb(1'b0, `OFS_DIV_CFG, 32'h0);
		check(rd, 32'h001F0300 | ((1 << e[0]) - 1));
		apb(1'b0, `OFS_INT_STATUS, 32'h0);
		check(rd & 32'h6, 32'h6);
		apb(1'b1, `OFS_INT_EN, 32'h0);
		repeat (2) @(posedge core_clk);
		check(irq, 1'b0);
		$display("test loss done");
		apb(1'b1, `OFS_CTRL, 32'h1);
		ref_half <= 8'h04;
		apb(1'b1, `OFS_DIV_CFG, 32'h001F0100);
		repeat (4) @(posedge core_clk);
		check({sk2, sk1, sk0, lock}, 16'h0);
		measure(2048);
		check(near(rises[0], rises[3]) && near(rises[1], rises[3] / 2)
			&& near(rises[2], rises[3] / 32), 1'b1);
		ref_half <= 8'h00;
		repeat (8) @(posedge core_clk);
		d = div_clk;
		repeat (50) @(posedge core_clk);
		check(div_clk, d);
		$display("test bypass done");
		rstn <= 1'b0;
		@(negedge core_clk);
		check({div_clk, lock}, 4'h0);
		rstn <= 1'b1;
		$display("test reset done");
		results;
	end
	initial begin
		#400000;
		n_errors = n_errors + 1;
		results;
	end
endmodule
